// *** shared/dycc_pkg.sv ***
// Constants shared by the yoke channel control block.
package dycc_pkg;
	// Clock rate and power-up timing.
	localparam int CLK_HZ = 20_000_000;
	localparam int HOURS_SHOW_MS = 2000;
	localparam int HOURS_SHOW_CYC = HOURS_SHOW_MS * (CLK_HZ / 1000);
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_PAN = 8'h08;
	localparam logic [7:0] ADDR_TILT = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_POS = 8'h14;
	// Field positions.
	localparam int CTRL_PROG_BIT = 0;
	localparam int CFG_BASE_LSB = 0;
	localparam int CFG_SPLIT_BIT = 16;
	localparam int CFG_LAMP_BIT = 17;
	localparam int CFG_BARN_BIT = 18;
	localparam int PAN_MID_LSB = 0;
	localparam int PAN_ANG_LSB = 16;
	localparam int TILT_ZERO_LSB = 0;
	localparam int TILT_DOWN_LSB = 16;
	localparam int TILT_UP_LSB = 24;
	// Reset values.
	localparam logic [9:0] BASE_RST = 10'h001;
	localparam logic [11:0] TRIM_RST = 12'h800;
	localparam logic [7:0] ANGLE_RST = 8'h5a;
	localparam logic [7:0] TILT_DOWN_RST = 8'h5a;
	localparam logic [7:0] TILT_UP_RST = 8'h14;
	// Accepted setting ranges.
	localparam logic [9:0] BASE_MIN = 10'h001;
	localparam logic [9:0] BASE_MAX = 10'h200;
	localparam logic [7:0] ANGLE_MIN = 8'h01;
	localparam logic [7:0] ANGLE_MAX = 8'hb9;
	localparam logic [7:0] TILT_MIN = 8'h0a;
	localparam logic [7:0] TILT_MAX = 8'hb6;
	localparam logic [11:0] TRIM_MIN = 12'h7d0;
	localparam logic [11:0] TRIM_MAX = 12'h834;
	// Slot storage depth and bus answers.
	localparam int SLOT_MAX = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power-up sequence states.
	typedef enum logic [1:0] {PU_TEST, PU_HOURS, PU_RUN, PU_FAIL} dycc_pwr_t;
endpackage : dycc_pkg

// *** logic/dycc_axis.sv ***
// One positioning axis: scales a 16-bit command into limits and slews toward it.
`timescale 1ns/100ps
module dycc_axis #(
	parameter int POS_W = 12,
	parameter int CPD_Q8 = 2913
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Motion control.
	input wire logic run_i,
	input wire logic home_i,
	input wire logic [15:0] pos_cmd_i,
	input wire logic [7:0] speed_i,
	// Limits around the reference position.
	input wire logic [POS_W-1:0] ref_i,
	input wire logic [7:0] neg_deg_i,
	input wire logic [7:0] pos_deg_i,
	// Axis state.
	output logic [POS_W-1:0] pos_o,
	output logic moving_o
);
	localparam logic [15:0] CPD = 16'(CPD_Q8);
	localparam logic [17:0] POS_TOP = 18'((1 << POS_W) - 1);
	logic [13:0] step_cnt_r;
	logic [POS_W-1:0] pos_r;
	wire [8:0] span = {1'b0, neg_deg_i} + {1'b0, pos_deg_i};
	wire [24:0] cmd_span = pos_cmd_i * span;
	wire [40:0] scaled_full = cmd_span * CPD;
	wire [23:0] off_full = neg_deg_i * CPD;
	wire signed [17:0] tgt_s;
	wire [POS_W-1:0] tgt;
	wire [POS_W-1:0] goal;
	wire [13:0] period = {~speed_i, 6'h3f};
	wire step = (step_cnt_r >= period);
	wire active = run_i | home_i;

	// Command spans neg..pos degrees around the reference, clamped to the encoder range.
	assign tgt_s = $signed({{(18 - POS_W){1'b0}}, ref_i}) + $signed({1'b0, scaled_full[40:24]})
		- $signed({2'b0, off_full[23:8]});
	assign tgt = tgt_s < 0 ? '0 : (tgt_s > $signed(POS_TOP) ? POS_TOP[POS_W-1:0] :
		tgt_s[POS_W-1:0]);
	assign goal = home_i ? ref_i : tgt;
	assign moving_o = active && (pos_r != goal);
	assign pos_o = pos_r;

	// Higher speed byte shortens the step period.
	always_ff @(posedge clk_i) begin
		if (rst_i || step || !active) begin
			step_cnt_r <= '0;
		end else begin
			step_cnt_r <= step_cnt_r + 14'h1;
		end
	end

	// One encoder count per step toward the goal.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_r <= '0;
		end else if (active && step && pos_r < goal) begin
			pos_r <= pos_r + 1'b1;
		end else if (active && step && pos_r > goal) begin
			pos_r <= pos_r - 1'b1;
		end
	end

	a_axis_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!active |=> $stable(pos_r)) else $error("axis moved while idle");
	a_axis_step: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(pos_r) |-> $past(step) && $past(active)) else $error("step without timer");
	a_home_seek: assert property (@(posedge clk_i) disable iff (rst_i)
		home_i && step && pos_r < ref_i |=> pos_r == $past(pos_r) + 1'b1)
		else $error("home did not move toward reference");
endmodule : dycc_axis

// *** logic/dycc_top.sv ***
// Yoke channel control: slot decode, modes, limits, display and AXI4-Lite registers.
// Overview of operation
// - Programming mode freezes slot capture and all axis motion except trim seeking until operating mode returns.
// - Two confirm key presses in succession leave programming mode.
// - Power-up runs self-test, shows operating hours, then drives axes to command.
// - Pan moves the programmed angle each side of the pan middle position.
// - Pan travel angle settings outside 1 to 185 are refused.
// - Tilt has separate down and up limits around the tilt zero position.
// - In programming mode a changed tilt zero trim drives tilt to the trimmed zero position.
// - Display shows base address and the value received on that slot.
// - Backlight is on automatically with an error or in programming mode.
// - At working level the light key toggles the backlight.
// - Speed split selects combined or separate speed slots and shifts later slots.
// - Slots 1 to 4 are pan and tilt coarse and fine from base.
// - The footprint spans 5 to 11 slots with options and split setting.
// - Base address settings outside 1 to 512 are refused.
// - Lamp rotation enable gates the lamp rotation output.
// - Barndoor enable gates the four leaf outputs.
`timescale 1ns/100ps
module dycc_top #(
	parameter int HOURS_CYC = dycc_pkg::HOURS_SHOW_CYC
) (
	// Clock and reset.
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	// AXI4-Lite write channels.
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// AXI4-Lite read channels.
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// Received slot stream from the line receiver.
	input wire logic SLOT_STB_I,
	input wire logic [9:0] SLOT_NUM_I,
	input wire logic [7:0] SLOT_DATA_I,
	// Front panel keys and status pins.
	input wire logic KEY_MENU_I,
	input wire logic KEY_OK_I,
	input wire logic KEY_LIGHT_I,
	input wire logic SELFTEST_DONE_I,
	input wire logic SELFTEST_PASS_I,
	input wire logic FAULT_I,
	// Axis and accessory outputs.
	output logic [11:0] PAN_POS_O,
	output logic [11:0] TILT_POS_O,
	output logic [7:0] LAMP_ROT_O,
	output logic [7:0] LEAF1_O,
	output logic [7:0] LEAF2_O,
	output logic [7:0] LEAF3_O,
	output logic [7:0] LEAF4_O,
	// Display.
	output logic SHOW_HOURS_O,
	output logic [9:0] DISP_ADDR_O,
	output logic [7:0] DISP_VALUE_O,
	output logic BACKLIGHT_O,
	output logic PROG_MODE_O
);
	dycc_pkg::dycc_pwr_t pwr_r;
	logic [5:0] meta_r, sync_r;
	logic [2:0] key_prev_r;
	logic [31:0] hours_cnt_r;
	logic prog_r, ok_once_r, light_r, tilt_home_r, pan_home_r;
	logic [7:0] slot_r [dycc_pkg::SLOT_MAX];
	logic [7:0] disp_val_r;
	logic [9:0] base_r;
	logic split_r, lamp_en_r, barn_en_r;
	logic [11:0] pan_mid_r, tilt_zero_r;
	logic [7:0] pan_ang_r, tilt_down_r, tilt_up_r;
	logic aw_r, w_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	wire [11:0] pan_pos, tilt_pos;
	// Key and status pins pass two flip-flops before use.
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			meta_r <= '0;
			sync_r <= '0;
			key_prev_r <= '0;
		end else begin
			meta_r <= {FAULT_I, SELFTEST_PASS_I, SELFTEST_DONE_I, KEY_LIGHT_I, KEY_OK_I, KEY_MENU_I};
			sync_r <= meta_r;
			key_prev_r <= sync_r[2:0];
		end
	end
	// Key press pulses and derived mode terms.
	wire [2:0] press = sync_r[2:0] & ~key_prev_r;
	wire menu_p = press[0];
	wire ok_p = press[1];
	wire light_p = press[2];
	wire fault = sync_r[5];
	wire running = (pwr_r == dycc_pkg::PU_RUN);
	wire capture_en = running && !prog_r;
	// Power-up sequence: self-test, hours display, then normal running.
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			pwr_r <= dycc_pkg::PU_TEST;
			hours_cnt_r <= '0;
		end else begin
			case (pwr_r)
				dycc_pkg::PU_TEST: begin
					if (sync_r[3]) begin
						pwr_r <= sync_r[4] ? dycc_pkg::PU_HOURS : dycc_pkg::PU_FAIL;
					end
				end
				dycc_pkg::PU_HOURS: begin
					hours_cnt_r <= hours_cnt_r + 32'h1;
					if (hours_cnt_r == 32'(HOURS_CYC - 1)) begin
						pwr_r <= dycc_pkg::PU_RUN;
					end
				end
				dycc_pkg::PU_RUN, dycc_pkg::PU_FAIL: pwr_r <= pwr_r;
				default: pwr_r <= dycc_pkg::PU_TEST;
			endcase
		end
	end
	// AXI4-Lite decode terms.
	wire [7:0] wa = awaddr_r;
	wire wr_go = aw_r && w_r && !bvalid_r;
	wire [31:0] strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [31:0] wr_word = (reg_view(wa) & ~strb_mask) | (wdata_r & strb_mask);
	wire wr_map = (wa == dycc_pkg::ADDR_CTRL) || (wa == dycc_pkg::ADDR_CFG) ||
		(wa == dycc_pkg::ADDR_PAN) || (wa == dycc_pkg::ADDR_TILT);
	wire rd_map = (S_AXI_ARADDR_I <= dycc_pkg::ADDR_POS) && (S_AXI_ARADDR_I[1:0] == 2'h0);
	wire [9:0] new_base = wr_word[dycc_pkg::CFG_BASE_LSB +: 10];
	wire [7:0] new_ang = wr_word[dycc_pkg::PAN_ANG_LSB +: 8];
	wire [11:0] new_mid = wr_word[dycc_pkg::PAN_MID_LSB +: 12];
	wire [11:0] new_zero = wr_word[dycc_pkg::TILT_ZERO_LSB +: 12];
	wire [7:0] new_down = wr_word[dycc_pkg::TILT_DOWN_LSB +: 8];
	wire [7:0] new_up = wr_word[dycc_pkg::TILT_UP_LSB +: 8];
	wire base_ok = new_base >= dycc_pkg::BASE_MIN && new_base <= dycc_pkg::BASE_MAX;
	wire ang_ok = new_ang >= dycc_pkg::ANGLE_MIN && new_ang <= dycc_pkg::ANGLE_MAX;
	wire mid_ok = new_mid >= dycc_pkg::TRIM_MIN && new_mid <= dycc_pkg::TRIM_MAX;
	wire zero_ok = new_zero >= dycc_pkg::TRIM_MIN && new_zero <= dycc_pkg::TRIM_MAX;
	wire down_ok = new_down >= dycc_pkg::TILT_MIN && new_down <= dycc_pkg::TILT_MAX;
	wire up_ok = new_up >= dycc_pkg::TILT_MIN && new_up <= dycc_pkg::TILT_MAX;
	wire wr_pan = wr_go && wa == dycc_pkg::ADDR_PAN;
	wire wr_tilt = wr_go && wa == dycc_pkg::ADDR_TILT;
	wire wr_ctrl = wr_go && wa == dycc_pkg::ADDR_CTRL;
	// Slot layout and footprint.
	wire [3:0] footprint = barn_en_r ? 4'(10 + split_r) : 4'(5 + split_r + lamp_en_r);
	wire [9:0] slot_off = SLOT_NUM_I - base_r;
	wire slot_hit = SLOT_STB_I && SLOT_NUM_I >= base_r && slot_off < {6'h0, footprint};
	wire [3:0] lamp_idx = split_r ? 4'h6 : 4'h5;
	wire [3:0] leaf_idx = split_r ? 4'h7 : 4'h6;
	wire [7:0] tilt_speed = split_r ? slot_r[5] : slot_r[4];
	// Mode status word.
	wire [31:0] stat_word = {10'h0, pwr_r, fault, BACKLIGHT_O, prog_r, light_r,
		disp_val_r, footprint, 4'h0};
	// Register view used for reads and for byte-lane merging on writes.
	function automatic logic [31:0] reg_view(input logic [7:0] a);
		case (a)
			dycc_pkg::ADDR_CTRL: reg_view = {31'h0, prog_r};
			dycc_pkg::ADDR_CFG: reg_view = {13'h0, barn_en_r, lamp_en_r, split_r, 6'h0, base_r};
			dycc_pkg::ADDR_PAN: reg_view = {8'h0, pan_ang_r, 4'h0, pan_mid_r};
			dycc_pkg::ADDR_TILT: reg_view = {tilt_up_r, tilt_down_r, 4'h0, tilt_zero_r};
			dycc_pkg::ADDR_STAT: reg_view = stat_word;
			dycc_pkg::ADDR_POS: reg_view = {4'h0, tilt_pos, 4'h0, pan_pos};
			default: reg_view = 32'h0;
		endcase
	endfunction : reg_view
	// Configuration registers: out-of-range settings are refused and keep their value.
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			base_r <= dycc_pkg::BASE_RST;
			{split_r, lamp_en_r, barn_en_r} <= 3'h0;
			pan_mid_r <= dycc_pkg::TRIM_RST;
			tilt_zero_r <= dycc_pkg::TRIM_RST;
			pan_ang_r <= dycc_pkg::ANGLE_RST;
			tilt_down_r <= dycc_pkg::TILT_DOWN_RST;
			tilt_up_r <= dycc_pkg::TILT_UP_RST;
		end else begin
			if (wr_go && wa == dycc_pkg::ADDR_CFG) begin
				if (base_ok) base_r <= new_base;
				split_r <= wr_word[dycc_pkg::CFG_SPLIT_BIT];
				lamp_en_r <= wr_word[dycc_pkg::CFG_LAMP_BIT];
				barn_en_r <= wr_word[dycc_pkg::CFG_BARN_BIT];
			end
			if (wr_pan && ang_ok) pan_ang_r <= new_ang;
			if (wr_pan && mid_ok) pan_mid_r <= new_mid;
			if (wr_tilt && zero_ok) tilt_zero_r <= new_zero;
			if (wr_tilt && down_ok) tilt_down_r <= new_down;
			if (wr_tilt && up_ok) tilt_up_r <= new_up;
		end
	end
	// Programming mode, confirm-key pairing, trim seeking and manual backlight.
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			{prog_r, ok_once_r, light_r, tilt_home_r, pan_home_r} <= 5'h0;
		end else begin
			if (!running) begin
				prog_r <= 1'b0;
			end else if (wr_ctrl && wstrb_r[0]) begin
				prog_r <= wdata_r[dycc_pkg::CTRL_PROG_BIT];
			end else if (menu_p) begin
				prog_r <= 1'b1;
			end else if (ok_p && prog_r && ok_once_r) begin
				prog_r <= 1'b0;
			end
			ok_once_r <= prog_r && !menu_p && (ok_once_r ^ ok_p);
			tilt_home_r <= prog_r &&
				(tilt_home_r || (wr_tilt && zero_ok && new_zero != tilt_zero_r));
			pan_home_r <= prog_r &&
				(pan_home_r || (wr_pan && mid_ok && new_mid != pan_mid_r));
			if (light_p && capture_en) light_r <= !light_r;
		end
	end
	// Slot capture: every entry takes its byte only outside programming mode.
	for (genvar i = 0; i < dycc_pkg::SLOT_MAX; i++) begin : g_slot
		always_ff @(posedge CORE_CLK_I) begin
			if (RESET_I) begin
				slot_r[i] <= 8'h0;
			end else if (capture_en && slot_hit && slot_off == 10'(i)) begin
				slot_r[i] <= SLOT_DATA_I;
			end
		end
	end
	// The base slot value is shown whatever the mode.
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			disp_val_r <= 8'h0;
		end else if (SLOT_STB_I && SLOT_NUM_I == base_r) begin
			disp_val_r <= SLOT_DATA_I;
		end
	end
	// Pan and tilt axes.
	dycc_axis u_pan (
		.clk_i(CORE_CLK_I), .rst_i(RESET_I), .run_i(capture_en), .home_i(pan_home_r),
		.pos_cmd_i({slot_r[0], slot_r[1]}), .speed_i(slot_r[4]), .ref_i(pan_mid_r),
		.neg_deg_i(pan_ang_r), .pos_deg_i(pan_ang_r), .pos_o(pan_pos), .moving_o());
	dycc_axis u_tilt (
		.clk_i(CORE_CLK_I), .rst_i(RESET_I), .run_i(capture_en), .home_i(tilt_home_r),
		.pos_cmd_i({slot_r[2], slot_r[3]}), .speed_i(tilt_speed), .ref_i(tilt_zero_r),
		.neg_deg_i(tilt_down_r), .pos_deg_i(tilt_up_r), .pos_o(tilt_pos), .moving_o());
	// AXI4-Lite slave: address and data taken in either order, one answer each.
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			{aw_r, w_r, bvalid_r, rvalid_r} <= 4'h0;
			awaddr_r <= 8'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			{bresp_r, rresp_r} <= 4'h0;
			rdata_r <= 32'h0;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
				aw_r <= 1'b1;
				awaddr_r <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
				w_r <= 1'b1;
				wdata_r <= S_AXI_WDATA_I;
				wstrb_r <= S_AXI_WSTRB_I;
			end
			if (wr_go) begin
				{aw_r, w_r, bvalid_r} <= 3'h1;
				bresp_r <= wr_map ? dycc_pkg::RESP_OKAY : dycc_pkg::RESP_SLVERR;
			end else if (bvalid_r && S_AXI_BREADY_I) begin
				bvalid_r <= 1'b0;
			end
			if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_map ? reg_view(S_AXI_ARADDR_I) : 32'h0;
				rresp_r <= rd_map ? dycc_pkg::RESP_OKAY : dycc_pkg::RESP_SLVERR;
			end else if (rvalid_r && S_AXI_RREADY_I) begin
				rvalid_r <= 1'b0;
			end
		end
	end
	// Bus handshake outputs.
	assign S_AXI_AWREADY_O = !aw_r && !bvalid_r;
	assign S_AXI_WREADY_O = !w_r && !bvalid_r;
	assign S_AXI_BVALID_O = bvalid_r;
	assign S_AXI_BRESP_O = bresp_r;
	assign S_AXI_ARREADY_O = !rvalid_r;
	assign S_AXI_RVALID_O = rvalid_r;
	assign S_AXI_RDATA_O = rdata_r;
	assign S_AXI_RRESP_O = rresp_r;
	// Device outputs.
	assign PAN_POS_O = pan_pos;
	assign TILT_POS_O = tilt_pos;
	assign LAMP_ROT_O = lamp_en_r ? slot_r[lamp_idx] : 8'h0;
	assign LEAF1_O = barn_en_r ? slot_r[leaf_idx] : 8'h0;
	assign LEAF2_O = barn_en_r ? slot_r[leaf_idx + 4'h1] : 8'h0;
	assign LEAF3_O = barn_en_r ? slot_r[leaf_idx + 4'h2] : 8'h0;
	assign LEAF4_O = barn_en_r ? slot_r[leaf_idx + 4'h3] : 8'h0;
	assign SHOW_HOURS_O = (pwr_r == dycc_pkg::PU_HOURS);
	assign DISP_ADDR_O = base_r;
	assign DISP_VALUE_O = disp_val_r;
	assign BACKLIGHT_O = prog_r || fault || pwr_r == dycc_pkg::PU_FAIL || light_r;
	assign PROG_MODE_O = prog_r;
	// Checks on modes, capture and the bus.
	sequence s_ok_key(armed);
		prog_r && ok_once_r == armed && ok_p && !menu_p && !wr_ctrl;
	endsequence
	a_prog_freeze: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		prog_r |=> $stable(slot_r[0]) && $stable(slot_r[2])) else $error("slot moved in setup");
	a_ok_exit: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		s_ok_key(1'b1) |=> !prog_r) else $error("second confirm did not exit");
	a_ok_first: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		s_ok_key(1'b0) |=> prog_r && ok_once_r) else $error("single confirm left setup");
	a_run_after_hours: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		running && !$past(running) |-> $past(SHOW_HOURS_O)) else $error("run without hours");
	a_angle_range: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		pan_ang_r >= dycc_pkg::ANGLE_MIN && pan_ang_r <= dycc_pkg::ANGLE_MAX)
		else $error("pan angle out of range");
	a_backlight_auto: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		prog_r || fault |-> BACKLIGHT_O) else $error("backlight off in setup or fault");
	a_light_toggle: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		light_p && capture_en |=> light_r != $past(light_r)) else $error("light key lost");
	a_trim_home: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		prog_r && wr_tilt && zero_ok && new_zero != tilt_zero_r |=> tilt_home_r [*1])
		else $error("trim change did not seek");
	a_wr_answer: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		wr_go |=> bvalid_r && bresp_r == (($past(wr_map)) ? dycc_pkg::RESP_OKAY :
		dycc_pkg::RESP_SLVERR)) else $error("write answer wrong");
endmodule : dycc_top

// *** bench/dycc_console_model.sv ***
// Behavioural lighting console that sends one frame of twelve consecutive slots.
`timescale 1ns/100ps
module dycc_console_model (
	// Clock.
	input wire logic clk_i,
	// Frame request.
	input wire logic go_i,
	input wire logic [9:0] base_i,
	input wire logic [95:0] frame_i,
	// Slot stream.
	output logic stb_o,
	output logic [9:0] num_o,
	output logic [7:0] data_o,
	output logic busy_o
);
	logic [3:0] idx_r;
	// Start idle.
	initial begin
		stb_o = 1'b0;
		num_o = 10'h000;
		data_o = 8'h00;
		busy_o = 1'b0;
		idx_r = 4'h0;
	end
	// Strobes alternate with idle cycles; idle lines carry inverted junk, but after a frame they return to the last slot's data every other cycle.
	always @(posedge clk_i) begin
		if (go_i && !busy_o) begin
			busy_o <= 1'b1;
			idx_r <= 4'h0;
		end else if (stb_o || !busy_o) begin
			stb_o <= 1'b0;
			num_o <= ~num_o;
			data_o <= ~data_o;
		end else if (idx_r == 4'hc) begin
			busy_o <= 1'b0;
		end else begin
			stb_o <= 1'b1;
			num_o <= base_i + {6'h00, idx_r};
			data_o <= frame_i[idx_r*8 +: 8];
			idx_r <= idx_r + 4'h1;
		end
	end
endmodule : dycc_console_model

// *** bench/dmx_yoke_channel_control_tb.sv ***
// Self-checking bench for the yoke channel control block.
`timescale 1ns/100ps
module dmx_yoke_channel_control_tb;
	logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic go = 1'b0, sdn = 1'b0, spa = 1'b0, flt = 1'b0;
	logic [2:0] ky = 3'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdo, rdv;
	logic [9:0] base = 10'h001, num, da;
	logic [95:0] fv = 96'h0;
	logic awr, wr_r, bv, arr, rv, stb, busy, hrs, bl, pm;
	logic [1:0] br, rr, rsp;
	logic [7:0] sd, lamp, l1, l2, l3, l4, dv;
	logic [11:0] pp, tp;
	int n_errors = 0, tests_run = 0, cyc = 0;
	integer seed = 32'hf482;
	// Clock and hang guard.
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	dycc_top #(.HOURS_CYC(20)) dut (.CORE_CLK_I(clk), .RESET_I(rst),
		.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
		.S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
		.S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdo), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
		.SLOT_STB_I(stb), .SLOT_NUM_I(num), .SLOT_DATA_I(sd),
		.KEY_MENU_I(ky[0]), .KEY_OK_I(ky[1]), .KEY_LIGHT_I(ky[2]),
		.SELFTEST_DONE_I(sdn), .SELFTEST_PASS_I(spa), .FAULT_I(flt),
		.PAN_POS_O(pp), .TILT_POS_O(tp), .LAMP_ROT_O(lamp),
		.LEAF1_O(l1), .LEAF2_O(l2), .LEAF3_O(l3), .LEAF4_O(l4),
		.SHOW_HOURS_O(hrs), .DISP_ADDR_O(da), .DISP_VALUE_O(dv), .BACKLIGHT_O(bl),
		.PROG_MODE_O(pm));
	dycc_console_model console (.clk_i(clk), .go_i(go), .base_i(base), .frame_i(fv),
		.stb_o(stb), .num_o(num), .data_o(sd), .busy_o(busy));
	// Compare and count.
	task check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check
	// Write one word; address and data are released each on its own ready.
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge clk);
			if (awv && awr === 1'b1) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr_r === 1'b1) begin
				dd = 1'b1;
				wv <= 1'b0;
			end
		end
		@(posedge clk);
		while (bv !== 1'b1) @(posedge clk);
		check({30'h0, br}, {30'h0, er});
		bry <= 1'b0;
		@(posedge clk);
	endtask : wr
	// Read one word.
	task rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		@(posedge clk);
		while (arr !== 1'b1) @(posedge clk);
		arv <= 1'b0;
		@(posedge clk);
		while (rv !== 1'b1) @(posedge clk);
		rdv = rdo;
		rsp = rr;
		rry <= 1'b0;
		@(posedge clk);
	endtask : rd
	// Read and compare masked fields.
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		check(rdv & m, e);
	endtask : rc
	// Write then read back.
	task wchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] e);
		wr(a, d, dycc_pkg::RESP_OKAY);
		rc(a, m, e);
	endtask : wchk
	// Press one front key long enough for the synchroniser.
	task press(input int b);
		ky[b] <= 1'b1;
		repeat (6) @(posedge clk);
		ky[b] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : press
	// Send a frame of fresh random slot values.
	task send(input logic [9:0] b);
		for (int i = 0; i < 12; i++) fv[i*8 +: 8] <= 8'($random(seed));
		base <= b;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		while (busy === 1'b1) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask : send
	// Expected slot value and footprint.
	function logic [7:0] sl(input int i);
		return fv[i*8 +: 8];
	endfunction : sl
	function logic [3:0] fp(input logic s, input logic l, input logic b);
		return b ? 4'ha + {3'h0, s} : 4'h5 + {3'h0, s} + {3'h0, l};
	endfunction : fp
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish
	// Main sequence.
	initial begin
		logic s, l, b;
		logic [9:0] bs;
		logic [7:0] keep;
		logic [11:0] pk, tk;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(dycc_pkg::ADDR_CFG, 32'h0007_03ff, 32'h1);
		rc(dycc_pkg::ADDR_PAN, 32'h00ff_0fff, 32'h005a_0800);
		rc(dycc_pkg::ADDR_TILT, 32'hffff_0fff, 32'h145a_0800);
		rd(8'h18);
		check({30'h0, rsp}, {30'h0, dycc_pkg::RESP_SLVERR});
		wr(8'h20, 32'h0, dycc_pkg::RESP_SLVERR);
		sdn <= 1'b1;
		spa <= 1'b1;
		for (int t = 0; t < 20 && hrs !== 1'b1; t++) @(posedge clk);
		check(hrs, 1'b1);
		for (int t = 0; t < 40 && hrs !== 1'b0; t++) @(posedge clk);
		rc(dycc_pkg::ADDR_STAT, 32'h0030_0000, 32'h0020_0000);
		check(bl, 1'b0);
		flt <= 1'b1;
		repeat (5) @(posedge clk);
		check(bl, 1'b1);
		flt <= 1'b0;
		press(2);
		check(bl, 1'b1);
		press(2);
		check(bl, 1'b0);
		for (int k = 0; k < 8; k++) begin
			{b, l, s} = 3'(k);
			bs = 10'h002 + {2'h0, 8'($random(seed))};
			if (k == 0) bs = 10'h001;
			if (k == 7) bs = 10'h1f6;
			wr(dycc_pkg::ADDR_CFG, {13'h0, b, l, s, 6'h0, bs}, dycc_pkg::RESP_OKAY);
			send(bs);
			rc(dycc_pkg::ADDR_STAT, 32'hf0, {24'h0, fp(s, l, b), 4'h0});
			check(da, bs);
			check(dv, sl(0));
			check(lamp, l ? sl(5 + s) : 8'h00);
			check({l1, l2, l3, l4}, b ? {sl(6 + s), sl(7 + s), sl(8 + s), sl(9 + s)} : 0);
		end
		wchk(dycc_pkg::ADDR_CFG, 32'h0, 32'h3ff, 32'h1f6);
		wchk(dycc_pkg::ADDR_CFG, 32'h201, 32'h3ff, 32'h1f6);
		wchk(dycc_pkg::ADDR_CFG, 32'h200, 32'h3ff, 32'h200);
		wchk(dycc_pkg::ADDR_PAN, 32'h0000_0800, 32'hff_0000, 32'h5a_0000);
		wchk(dycc_pkg::ADDR_PAN, 32'h00ba_0800, 32'hff_0000, 32'h5a_0000);
		wchk(dycc_pkg::ADDR_PAN, 32'h00b9_0800, 32'hff_0000, 32'hb9_0000);
		wchk(dycc_pkg::ADDR_PAN, 32'h0001_0800, 32'hff_0000, 32'h01_0000);
		wchk(dycc_pkg::ADDR_TILT, 32'hb60a_0800, 32'hffff_0000, 32'hb60a_0000);
		wr(dycc_pkg::ADDR_CFG, 32'h0007_0010, dycc_pkg::RESP_OKAY);
		send(10'h010);
		keep = sl(6);
		press(0);
		check(pm, 1'b1);
		check(bl, 1'b1);
		pk = pp;
		tk = tp;
		send(10'h010);
		repeat (200) @(posedge clk);
		check(lamp, keep);
		check(dv, sl(0));
		check(pp, pk);
		check(tp, tk);
		wr(dycc_pkg::ADDR_TILT, 32'hb60a_0801, dycc_pkg::RESP_OKAY);
		rc(dycc_pkg::ADDR_TILT, 32'h0fff, 32'h0801);
		press(1);
		check(pm, 1'b1);
		press(1);
		check(pm, 1'b0);
		tally_and_finish;
	end
endmodule : dmx_yoke_channel_control_tb
